/* File: tb/rps_ext_model.sv */
// Model of the external logic that the block resets, powers and clocks
`timescale 1ns/10ps
`default_nettype none

module rps_ext_model
   import rps_pkg::*;
(
   // Clock
   input  wire logic              mclk,
   // Device pins seen from the board
   input  wire logic              reset_out_n,
   input  wire logic              power_enable_n,
   input  wire logic              osc_out,
   input  wire rps_pkg::rps_pin_t cfg_mem_select,
   input  wire rps_pkg::rps_pin_t cfg_mem_clock,
   input  wire rps_pkg::rps_pin_t cfg_mem_data_io,
   // Resolved wire levels and what the logic sees
   output var  logic [2:0]        mem_lvl,
   output var  logic              ext_powered,
   output var  logic              ext_in_reset,
   output var  logic [15:0]       osc_edges
);
   import rps_pkg::*;

   logic        osc_prev_r = 1'b0;             // Last oscillator level seen
   logic [15:0] edge_cnt_r = 16'h0000;         // Edges counted so far

   // ----------------------------------------
   // Wire resolution
   // ----------------------------------------
   // Released lines float up through the weak pull-ups, never hold the last value
   always_comb begin
      mem_lvl[0] = cfg_mem_select.oe ? cfg_mem_select.o : 1'b1;
      mem_lvl[1] = cfg_mem_clock.oe ? cfg_mem_clock.o : 1'b1;
      mem_lvl[2] = cfg_mem_data_io.oe ? cfg_mem_data_io.o : 1'b1;
   end

   // Power switch and reset of the external logic, both active low
   assign ext_powered  = !power_enable_n;
   assign ext_in_reset = !reset_out_n;

   // ----------------------------------------
   // Clock edges received from the oscillator output
   // ----------------------------------------
   // Free-running count; the bench only looks at differences
   assign osc_edges = edge_cnt_r;
   always_ff @(posedge mclk) begin
      osc_prev_r <= osc_out;
      if (osc_out != osc_prev_r) begin
         edge_cnt_r <= edge_cnt_r + 16'h0001;
      end
   end
endmodule : rps_ext_model

`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the reset and power-state block
`timescale 1ns/10ps
`default_nettype none

`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin err_count++; \
   $display("[ERR] %0t got %0h want %0h", $time, (act), (exp)); end end

module tb_top;
   import rps_pkg::*;

   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic       mclk = 1'b0;                    // 200 MHz clock
   logic       reset = 1'b1;                   // Synchronous reset
   logic       power_good = 1'b1;              // Supply good
   logic       osc_running = 1'b1;             // Oscillator started
   logic       ext_reset_n_i = 1'b1;           // External reset, active low
   logic       usb_configured = 1'b0;          // Host configured
   logic       usb_suspend = 1'b0;             // Bus suspended
   logic       usb_bus_reset = 1'b0;           // Bus reset seen
   rps_cfg_t   cfg_in = '0;                    // Memory absent
   logic       mem_i = 1'b0;                   // Reader levels, held idle
   logic       reset_out_n, power_enable_n, osc_out, pullup_en, in_reset;
   rps_pin_t   mem_sel, mem_clk, mem_dat, ext_pin;
   rps_modes_t chan_modes;
   logic [2:0] mem_lvl;
   logic       ext_powered, ext_in_reset;
   logic [15:0] osc_edges;
   int         err_count = 0;
   int         samples_checked = 0;
   localparam int unsigned TB_LOW = 600;       // Shortened reset interval so release fits the run

   // Clock, 5 ns period
   initial begin
      forever #2.5 mclk = ~mclk;
   end

   rps_top #(.LOW_CYCLES(TB_LOW)) i_rps_top (.MCLK(mclk), .RESET(reset), .POWER_GOOD(power_good),
      .OSC_RUNNING(osc_running),
      .EXT_RESET_N_I(ext_reset_n_i), .USB_CONFIGURED(usb_configured), .USB_SUSPEND(usb_suspend),
      .USB_BUS_RESET(usb_bus_reset), .CFG_IN(cfg_in), .CFG_MEM_CLOCK_I(mem_i), .CFG_MEM_SELECT_I(mem_i),
      .CFG_MEM_DATA_I(mem_i), .CFG_MEM_DATA_DRV(mem_i), .RESET_OUT_N(reset_out_n),
      .POWER_ENABLE_N(power_enable_n), .OSC_OUT(osc_out), .CFG_MEM_SELECT(mem_sel), .CFG_MEM_CLOCK(mem_clk),
      .CFG_MEM_DATA_IO(mem_dat), .EXT_RESET_N_PIN(ext_pin), .PULLUP_EN(pullup_en), .CHAN_MODES(chan_modes),
      .IN_RESET(in_reset));

   rps_ext_model i_rps_ext_model (.mclk(mclk), .reset_out_n(reset_out_n), .power_enable_n(power_enable_n),
      .osc_out(osc_out), .cfg_mem_select(mem_sel), .cfg_mem_clock(mem_clk), .cfg_mem_data_io(mem_dat),
      .mem_lvl(mem_lvl), .ext_powered(ext_powered), .ext_in_reset(ext_in_reset), .osc_edges(osc_edges));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Step n edges, then 1 ns on so that every update has landed
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Reset levels of every output while RESET is high
   task automatic t_reset_vals;
      `CHK(reset_out_n, 1'b0)
      `CHK(power_enable_n, 1'b1)
      `CHK(chan_modes, {MODE_UART, MODE_UART})
      `CHK({mem_sel.oe, mem_clk.oe, mem_dat.oe, ext_pin.oe}, 4'h0)
      `CHK({pullup_en, in_reset, osc_out}, 3'h6)
      `CHK(mem_lvl, 3'h7)
      $display("test reset_vals done");
   endtask : t_reset_vals

   // Start conditions good: low through the interval, then released with memory select and clock driven, data only while the reader drives it
   // Release lands two sync flops plus the output register after the count ends
   task automatic t_hold_low;
      for (int i = 0; i < TB_LOW; i++) begin
         cyc(1);
         `CHK(reset_out_n, 1'b0)
         `CHK(pullup_en, 1'b1)
         `CHK(mem_lvl, 3'h7)
      end
      cyc(2);
      `CHK(reset_out_n, 1'b0)
      cyc(1);
      `CHK(reset_out_n, 1'b1)
      `CHK({pullup_en, in_reset, ext_in_reset}, 3'h0)
      `CHK({mem_sel.oe, mem_clk.oe, mem_dat.oe, ext_pin.oe}, 4'hc)
      `CHK(mem_lvl, 3'h4)
      @(posedge mclk) mem_i <= 1'b1;
      cyc(1);
      `CHK({mem_sel.oe, mem_clk.oe, mem_dat.oe}, 3'h7)
      `CHK(mem_lvl, 3'h7)
      @(posedge mclk) mem_i <= 1'b0;
      $display("test hold_low done");
   endtask : t_hold_low

   // Bus resets leave the released output alone; power enable follows configuration and suspend
   task automatic t_bus_reset;
      @(posedge mclk) usb_configured <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge mclk) usb_bus_reset <= i[2];
         #1;
         `CHK(reset_out_n, 1'b1)
         `CHK({power_enable_n, ext_powered}, 2'h1)
      end
      @(posedge mclk) usb_suspend <= 1'b1;
      cyc(1);
      `CHK({power_enable_n, ext_powered}, 2'h2)
      @(posedge mclk) usb_suspend <= 1'b0;
      cyc(1);
      `CHK(power_enable_n, 1'b0)
      @(posedge mclk) begin
         usb_configured <= 1'b0;
         usb_bus_reset  <= 1'b0;
      end
      cyc(1);
      `CHK(power_enable_n, 1'b1)
      $display("test bus_reset done");
   endtask : t_bus_reset

   // External reset low drives the output low within three edges, then the full interval restarts
   task automatic t_ext_reset;
      @(posedge mclk) ext_reset_n_i <= 1'b0;
      cyc(3);
      `CHK({reset_out_n, ext_in_reset}, 2'h1)
      `CHK(ext_pin.oe, 1'b0)
      `CHK({mem_sel.oe, mem_clk.oe, mem_dat.oe, pullup_en}, 4'h1)
      `CHK(in_reset, 1'b1)
      @(posedge mclk) ext_reset_n_i <= 1'b1;
      cyc(TB_LOW + 2);
      `CHK(reset_out_n, 1'b0)
      cyc(1);
      `CHK(reset_out_n, 1'b1)
      $display("test ext_reset done");
   endtask : t_ext_reset

   // Oscillator half period, then no edges at all while suspended
   task automatic t_osc;
      logic [15:0] e0;
      int n;
      n = 0;
      e0 = osc_edges;
      while (osc_edges == e0 && n < 40) begin
         cyc(1);
         n++;
      end
      e0 = osc_edges;
      n = 0;
      while (osc_edges == e0 && n < 40) begin
         cyc(1);
         n++;
      end
      `CHK(n, int'(OSC_DIV_HALF))
      @(posedge mclk) usb_suspend <= 1'b1;
      cyc(3);
      e0 = osc_edges;
      cyc(200);
      `CHK(osc_edges, e0)
      @(posedge mclk) usb_suspend <= 1'b0;
      cyc(40);
      `CHK(osc_edges != e0, 1'b1)
      $display("test osc done");
   endtask : t_osc

   // Absent memory, then a blank one with every stored mode code, then a programmed one
   task automatic t_cfg_modes;
      for (int k = 0; k < 5; k++) begin
         @(posedge mclk) cfg_in <= '{present: (k > 0), blank: (k > 0), mode_a: 2'(k), mode_b: 2'(3 - k)};
         cyc(5);
         `CHK(chan_modes, {MODE_UART, MODE_UART})
      end
      @(posedge mclk) cfg_in <= '{present: 1'b1, blank: 1'b0, mode_a: MODE_FIFO, mode_b: MODE_OPTO};
      cyc(2);
      `CHK(chan_modes, {MODE_FIFO, MODE_OPTO})
      $display("test cfg_modes done");
   endtask : t_cfg_modes

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   // Second reset in mid-run must bring back every reset level
   initial begin
      cyc(3);
      t_reset_vals();
      @(posedge mclk) reset <= 1'b0;
      t_hold_low();
      t_bus_reset();
      t_ext_reset();
      t_osc();
      t_cfg_modes();
      @(posedge mclk) reset <= 1'b1;
      cyc(4);
      t_reset_vals();
      tally_and_finish();
   end

   // Tests need about 1,600 cycles; a hang is cut off well beyond that
   initial begin
      cyc(10000);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule : tb_top

`default_nettype wire

/* File: verilog/rps_pkg.sv */
// Package: constants and carrier types for the reset and power-state block
package rps_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_PS   = 5000;                 // 200 MHz MCLK, period in ps
   localparam int unsigned RST_LOW_TIME_US = 5600;                 // 5.6 ms reset output low time, in us
   // Cycles per microsecond first, so the product stays inside 32 bits
   localparam int unsigned RST_LOW_CYCLES  =
      RST_LOW_TIME_US * (1000000 / CLK_PERIOD_PS);                 // 200 cycles per us
   localparam int unsigned RST_CNT_W       = 21;                   // Wide enough for 1.12e6 cycles
   localparam int unsigned OSC_DIV_HALF    = 17;                   // Oscillator output half period, cycles

   // ----------------------------------------
   // Channel mode encodings
   // ----------------------------------------
   localparam logic [1:0] MODE_UART  = 2'h0;                       // Asynchronous serial port
   localparam logic [1:0] MODE_FIFO  = 2'h1;                       // Parallel FIFO
   localparam logic [1:0] MODE_CPU   = 2'h2;                       // CPU-style FIFO
   localparam logic [1:0] MODE_OPTO  = 2'h3;                       // Opto-isolated serial

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic       RST_OUT_INIT = 1'b0;                     // Reset output low at reset
   localparam logic       PWR_EN_INIT  = 1'b1;                     // Power enable off at reset

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed {
      logic o;                                                     // Driven level
      logic oe;                                                    // High while driving
   } rps_pin_t;

   typedef struct packed {
      logic       present;                                         // Memory answered
      logic       blank;                                           // Memory read all ones
      logic [1:0] mode_a;                                          // Stored mode, channel A
      logic [1:0] mode_b;                                          // Stored mode, channel B
   } rps_cfg_t;

   typedef struct packed {
      logic [1:0] mode_a;                                          // Chosen mode, channel A
      logic [1:0] mode_b;                                          // Chosen mode, channel B
   } rps_modes_t;

   // ----------------------------------------
   // Power state machine
   // ----------------------------------------
   typedef enum logic [2:0] {
      PS_OFF    = 3'b001,                                          // Not configured
      PS_ON     = 3'b010,                                          // Configured, awake
      PS_SUSP   = 3'b100                                           // Suspended
   } rps_pstate_t;

endpackage : rps_pkg

/* File: verilog/rps_sync.sv */
// Two-flop synchroniser for a vector of pin-side levels
`timescale 1ns/10ps
`default_nettype none

module rps_sync #(
   parameter int unsigned W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         MCLK,
   input  wire logic         RESET,
   // Data
   input  wire logic [W-1:0] D,
   output var  logic [W-1:0] Q
);

   logic [W-1:0] meta_r;                                           // First stage, read only by Q

   // ----------------------------------------
   // Two stages, one per bit
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // Each bit passes two flops
         always_ff @(posedge MCLK) begin
            if (RESET) begin
               meta_r[i] <= INIT[i];
               Q[i]      <= INIT[i];
            end else begin
               meta_r[i] <= D[i];
               Q[i]      <= meta_r[i];
            end
         end
      end
   endgenerate

endmodule : rps_sync

`default_nettype wire

/* File: verilog/rps_top.sv */
// Reset and power-state output generator
//
// Overview of operation
// - Reset output low 5.6 ms after start
// - External reset low forces reset output low
// - USB bus reset never touches reset output
// - Power enable low configured, high suspended
// - Memory pins and reset input float in reset
// - Memory clock driven whenever out of reset
// - Oscillator output stops during suspend
// - Absent or blank memory selects serial mode
`timescale 1ns/10ps
`default_nettype none

module rps_top
   import rps_pkg::*;
#(
   // Reset low interval in cycles; simulation may shorten it, silicon keeps the default
   parameter int unsigned LOW_CYCLES = RST_LOW_CYCLES
) (
   // Clock and reset
   input  wire logic             MCLK,
   input  wire logic             RESET,
   // Pin-side status levels
   input  wire logic             POWER_GOOD,     // Supply above threshold
   input  wire logic             OSC_RUNNING,    // Oscillator started
   input  wire logic             EXT_RESET_N_I,  // External reset pin level
   // USB state from the protocol engine
   input  wire logic             USB_CONFIGURED, // Host has configured
   input  wire logic             USB_SUSPEND,    // Bus in suspend
   input  wire logic             USB_BUS_RESET,  // Bus reset seen
   // Configuration memory status and memory pin levels from its reader
   input  wire rps_pkg::rps_cfg_t CFG_IN,
   input  wire logic             CFG_MEM_CLOCK_I,
   input  wire logic             CFG_MEM_SELECT_I,
   input  wire logic             CFG_MEM_DATA_I,
   input  wire logic             CFG_MEM_DATA_DRV,
   // Pins
   output var  logic             RESET_OUT_N,
   output var  logic             POWER_ENABLE_N,
   output var  logic             OSC_OUT,
   output var  rps_pkg::rps_pin_t CFG_MEM_SELECT,
   output var  rps_pkg::rps_pin_t CFG_MEM_CLOCK,
   output var  rps_pkg::rps_pin_t CFG_MEM_DATA_IO,
   output var  rps_pkg::rps_pin_t EXT_RESET_N_PIN,
   output var  logic             PULLUP_EN,
   // Chosen channel modes and internal reset
   output var  rps_pkg::rps_modes_t CHAN_MODES,
   output var  logic             IN_RESET
);

   import rps_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [2:0]           pins_s;                                   // Synchronised status levels
   logic                 pgood_s;                                  // Power good, synced
   logic                 osc_s;                                    // Oscillator running, synced
   logic                 ext_n_s;                                  // External reset, synced
   logic                 start_ok;                                 // All start conditions true
   logic [RST_CNT_W-1:0] cnt_r;                                    // Low-interval counter
   logic                 done_r;                                   // Interval complete
   rps_pstate_t          ps_r;                                     // Power state
   rps_pstate_t          ps_nxt;                                   // Next power state
   logic [4:0]           div_r;                                    // Oscillator divider
   logic                 osc_r;                                    // Oscillator output level

   // ----------------------------------------
   // Synchronise pin-side levels
   // ----------------------------------------
   rps_sync #(
      .W    (3),
      .INIT (3'h3)
   ) u_sync (
      .MCLK  (MCLK),
      .RESET (RESET),
      .D     ({POWER_GOOD, OSC_RUNNING, EXT_RESET_N_I}),
      .Q     (pins_s)
   );

   assign pgood_s  = pins_s[2];
   assign osc_s    = pins_s[1];
   assign ext_n_s  = pins_s[0];
   assign start_ok = pgood_s & osc_s & ext_n_s;

   // ----------------------------------------
   // Reset interval counter
   // ----------------------------------------
   // Any loss of a start condition restarts the full interval.
   // USB_BUS_RESET is deliberately not an input to this logic.
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else if (!start_ok) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else if (!done_r) begin
         if (cnt_r == RST_CNT_W'(LOW_CYCLES - 1)) begin
            done_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Reset output register
   // ----------------------------------------
   // Registered from done_r and start_ok so the pin never glitches.
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         RESET_OUT_N <= RST_OUT_INIT;
      end else begin
         RESET_OUT_N <= done_r & start_ok;
      end
   end

   assign IN_RESET = ~done_r;                                      // Internal device reset

   // ----------------------------------------
   // Power state machine
   // ----------------------------------------
   always_comb begin
      ps_nxt = ps_r;
      case (ps_r)
         PS_OFF: begin
            if (USB_CONFIGURED && !USB_SUSPEND) begin
               ps_nxt = PS_ON;
            end
         end
         PS_ON: begin
            if (!USB_CONFIGURED) begin
               ps_nxt = PS_OFF;
            end else if (USB_SUSPEND) begin
               ps_nxt = PS_SUSP;
            end
         end
         PS_SUSP: begin
            if (!USB_CONFIGURED) begin
               ps_nxt = PS_OFF;
            end else if (!USB_SUSPEND) begin
               ps_nxt = PS_ON;
            end
         end
         default: begin
            ps_nxt = PS_OFF;                                       // Recover from bad code
         end
      endcase
   end

   // State register, cleared in device reset
   always_ff @(posedge MCLK) begin
      if (RESET || !done_r) begin
         ps_r <= PS_OFF;
      end else begin
         ps_r <= ps_nxt;
      end
   end

   // Power enable output register
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         POWER_ENABLE_N <= PWR_EN_INIT;
      end else begin
         POWER_ENABLE_N <= (ps_nxt != PS_ON) | ~done_r;
      end
   end

   // ----------------------------------------
   // Oscillator output divider
   // ----------------------------------------
   // Stopped and held at its last level in suspend: external logic sees no edges.
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         div_r <= '0;
         osc_r <= 1'b0;
      end else if (USB_SUSPEND) begin
         div_r <= '0;
         osc_r <= osc_r;
      end else if (div_r == 5'(OSC_DIV_HALF - 1)) begin
         div_r <= '0;
         osc_r <= ~osc_r;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   assign OSC_OUT = osc_r;

   // ----------------------------------------
   // Memory and reset-input pins
   // ----------------------------------------
   // In reset all four float with pull-ups; after it the clock always drives.
   always_comb begin
      PULLUP_EN              = ~done_r;
      EXT_RESET_N_PIN.o      = 1'b0;
      EXT_RESET_N_PIN.oe     = 1'b0;
      CFG_MEM_CLOCK.o        = done_r & CFG_MEM_CLOCK_I;
      CFG_MEM_CLOCK.oe       = done_r;
      CFG_MEM_SELECT.o       = done_r & CFG_MEM_SELECT_I;
      CFG_MEM_SELECT.oe      = done_r;
      CFG_MEM_DATA_IO.o      = CFG_MEM_DATA_I;
      CFG_MEM_DATA_IO.oe     = done_r & CFG_MEM_DATA_DRV;
   end

   // ----------------------------------------
   // Channel mode selection
   // ----------------------------------------
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         CHAN_MODES <= '{mode_a: MODE_UART, mode_b: MODE_UART};
      end else if (!CFG_IN.present || CFG_IN.blank) begin
         CHAN_MODES <= '{mode_a: MODE_UART, mode_b: MODE_UART};
      end else begin
         CHAN_MODES <= '{mode_a: CFG_IN.mode_a, mode_b: CFG_IN.mode_b};
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_ext_forces_low: assert property (@(posedge MCLK) disable iff (RESET)
      !ext_n_s |=> !RESET_OUT_N)
      else $error("Reset output high while external reset low");
   a_low_interval: assert property (@(posedge MCLK) disable iff (RESET)
      $rose(start_ok) |=> !RESET_OUT_N [*8])
      else $error("Reset output released too early");
   a_release_cnt: assert property (@(posedge MCLK) disable iff (RESET)
      $rose(RESET_OUT_N) |-> cnt_r == RST_CNT_W'(LOW_CYCLES - 1))
      else $error("Reset output released at wrong count");
   a_start_gate: assert property (@(posedge MCLK) disable iff (RESET)
      !start_ok |=> cnt_r == '0)
      else $error("Counter ran without start conditions");
   a_busreset_ignored: assert property (@(posedge MCLK) disable iff (RESET)
      USB_BUS_RESET && start_ok && RESET_OUT_N |=> RESET_OUT_N)
      else $error("Bus reset affected reset output");
   a_pwr_suspend: assert property (@(posedge MCLK) disable iff (RESET)
      USB_SUSPEND |=> POWER_ENABLE_N)
      else $error("Power enable low in suspend");
   a_pwr_config: assert property (@(posedge MCLK) disable iff (RESET)
      done_r && ps_r == PS_ON && USB_CONFIGURED && !USB_SUSPEND |=> !POWER_ENABLE_N)
      else $error("Power enable high while configured");
   a_pins_float: assert property (@(posedge MCLK) disable iff (RESET)
      !done_r |-> !CFG_MEM_SELECT.oe && !CFG_MEM_CLOCK.oe && !CFG_MEM_DATA_IO.oe
         && !EXT_RESET_N_PIN.oe && PULLUP_EN)
      else $error("Memory pin driven in reset");
   a_clk_driven: assert property (@(posedge MCLK) disable iff (RESET)
      done_r |-> CFG_MEM_CLOCK.oe)
      else $error("Memory clock floating outside reset");
   a_osc_stop: assert property (@(posedge MCLK) disable iff (RESET)
      USB_SUSPEND [*2] |-> $stable(OSC_OUT))
      else $error("Oscillator output toggled in suspend");
   a_default_mode: assert property (@(posedge MCLK) disable iff (RESET)
      (!CFG_IN.present || CFG_IN.blank) |=> CHAN_MODES.mode_a == MODE_UART && CHAN_MODES.mode_b == MODE_UART)
      else $error("Default serial mode not selected");

   c_release:   cover property (@(posedge MCLK) disable iff (RESET) $rose(RESET_OUT_N));
   c_ext_reset: cover property (@(posedge MCLK) disable iff (RESET) RESET_OUT_N ##1 !ext_n_s);
   c_power_on:  cover property (@(posedge MCLK) disable iff (RESET) $fell(POWER_ENABLE_N));
   c_suspend:   cover property (@(posedge MCLK) disable iff (RESET) !POWER_ENABLE_N ##1 USB_SUSPEND);

endmodule : rps_top

`default_nettype wire
